// ### src/acs_pkg.sv
package acs_pkg;
    typedef enum logic [1:0] {
        ACS_IDLE,
        ACS_SAMPLE,
        ACS_CONVERT
    } acs_state_t;

    // software-written configuration
    typedef struct packed {
        logic powerEnable;
        logic resultFormatSelect;
        logic [2:0] clockSelect;
        logic [2:0] inputSourceSelect;
        logic [3:0] externalChannelSelect;
        logic [1:0] referenceSelect;
    } acs_cfg_t;

    // result register pair as software reads it
    typedef struct packed {
        logic [7:0] resultHighByte;
        logic [7:0] resultLowByte;
    } acs_result_t;
endpackage

// ### src/acs_regs.svh
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH

// converter timing in converter clock periods
`define ACS_SAMPLE_CYCLES 4
`define ACS_CONVERT_CYCLES 12
// clock select codes: divide system clock by 2**code, code 7 slowest
`define ACS_CLKSEL_W 3
`define ACS_RESULT_W 12
// reset values
`define ACS_RESULT_RST 12'h000
`define ACS_BYTE_RST 8'h00

`endif

// ### src/adc_conversion_sequencer.sv
`include "acs_regs.svh"
// What this block does
// - sample 4 then convert 12 converter clocks
// - conversion runs to completion without software
// - converter works only while power enabled
// - power cleared means analog circuits off
// - result format bit arranges high/low bytes
// - start bit low-high-low begins conversion
// - busy flag high during conversion
// - busy drops, result then valid
// - result is 12-bit unsigned code
module adc_conversion_sequencer #(
    parameter int SAMPLE_CYCLES = `ACS_SAMPLE_CYCLES,
    parameter int CONVERT_CYCLES = `ACS_CONVERT_CYCLES
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire acs_pkg::acs_cfg_t cfg,
    input wire logic startBit,
    input wire logic irqFlagClear,
    input wire logic compareHigh,
    output acs_pkg::acs_cfg_t analogCfg,
    output logic analogPowerOn,
    output logic analogSampling,
    output logic conversionBusyFlag,
    output logic converterInterruptRequest,
    output acs_pkg::acs_result_t result
);
    // phase counter wide enough for either count
    localparam int CW = 5;
    localparam logic [CW-1:0] SAMPLE_LAST = CW'(SAMPLE_CYCLES - 1);
    localparam logic [CW-1:0] CONVERT_LAST = CW'(CONVERT_CYCLES - 1);
    // msb of the code, first bit the approximation tries
    localparam logic [3:0] TOP_BIT = 4'(`ACS_RESULT_W - 1);

    acs_pkg::acs_state_t stateReg;
    logic [6:0] divReg;
    logic adcTick;
    logic startPrevReg;
    logic startArmedReg;
    logic [CW-1:0] cycleReg;
    logic [`ACS_RESULT_W-1:0] sarReg;
    logic [3:0] bitIdxReg;
    logic doneEvent;
    // start pulse completed: seen high, now low again
    logic fireEvent;

    // ticks the converter clock; shorter divides in the low bits
    function automatic logic divTick(input logic [6:0] cnt, input logic [2:0] sel);
        logic [6:0] mask;
        mask = 7'h7F >> (3'h7 - sel);
        divTick = ((cnt & mask) == mask) || (sel == 3'h0);
    endfunction

    // true on the last counted cycle of a phase;
    // shared by the sampling and the conversion phase
    function automatic logic lastCycle(input logic [CW-1:0] cnt, input logic [CW-1:0] last);
        lastCycle = (cnt == last);
    endfunction

    // free-running prescaler, held cleared while powered down
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            divReg <= 7'h00;
        end else if (!cfg.powerEnable) begin
            divReg <= 7'h00;
        end else begin
            divReg <= divReg + 7'h01;
        end
    end
    assign adcTick = divTick(divReg, cfg.clockSelect);

    // last start level; resets to the idle low level of the bit
    // so that no false edge follows reset
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            startPrevReg <= 1'b0;
        end else begin
            startPrevReg <= startBit;
        end
    end

    // start arms on the rising edge and fires on the falling one;
    // a bare falling edge without a rise is ignored
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            startArmedReg <= 1'b0;
        end else if (!cfg.powerEnable) begin
            startArmedReg <= 1'b0;
        end else if (startBit && !startPrevReg) begin
            startArmedReg <= 1'b1;
        end else if (!startBit && startPrevReg) begin
            startArmedReg <= 1'b0;
        end
    end
    assign fireEvent = startArmedReg && !startBit && startPrevReg;

    // sequencer: a new start pulse restarts any conversion underway
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stateReg <= acs_pkg::ACS_IDLE;
            cycleReg <= '0;
            sarReg <= `ACS_RESULT_RST;
            bitIdxReg <= 4'h0;
        end else if (!cfg.powerEnable) begin
            stateReg <= acs_pkg::ACS_IDLE;
            cycleReg <= '0;
        // a new pulse restarts any run in progress
        end else if (fireEvent) begin
            stateReg <= acs_pkg::ACS_SAMPLE;
            cycleReg <= '0;
            sarReg <= `ACS_RESULT_RST;
            bitIdxReg <= TOP_BIT;
        end else if (adcTick) begin
            case (stateReg)
                acs_pkg::ACS_SAMPLE: begin
                    if (lastCycle(cycleReg, SAMPLE_LAST)) begin
                        stateReg <= acs_pkg::ACS_CONVERT;
                        cycleReg <= '0;
                        sarReg[bitIdxReg] <= 1'b1;
                    end else begin
                        cycleReg <= cycleReg + CW'(1);
                    end
                end
                acs_pkg::ACS_CONVERT: begin
                    // trial bit kept if input above trial level
                    sarReg[bitIdxReg] <= compareHigh;
                    if (bitIdxReg != 4'h0) begin
                        sarReg[bitIdxReg - 4'h1] <= 1'b1;
                        bitIdxReg <= bitIdxReg - 4'h1;
                    end
                    if (lastCycle(cycleReg, CONVERT_LAST)) begin
                        stateReg <= acs_pkg::ACS_IDLE;
                        cycleReg <= '0;
                    end else begin
                        cycleReg <= cycleReg + CW'(1);
                    end
                end
                default: begin
                    stateReg <= acs_pkg::ACS_IDLE;
                end
            endcase
        end
    end
    // last convert tick; a start in the same cycle wins, so the
    // interrupted run leaves neither result nor request
    assign doneEvent = cfg.powerEnable && adcTick && (stateReg == acs_pkg::ACS_CONVERT)
        && lastCycle(cycleReg, CONVERT_LAST) && !fireEvent;

    // result latch; both bytes update with busy falling
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            result <= '0;
        end else if (doneEvent) begin
            if (cfg.resultFormatSelect) begin
                // right aligned: 4 msbs in high byte
                result <= {4'h0, sarReg[11:1], compareHigh};
            end else begin
                // left aligned: low nibble of low byte zero
                result <= {sarReg[11:1], compareHigh, 4'h0};
            end
        end
    end

    // busy covers the firing cycle too, so it spans all 16 converter
    // clocks; power loss drops it at once
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            conversionBusyFlag <= 1'b0;
        end else begin
            conversionBusyFlag <= cfg.powerEnable && !doneEvent
                && ((stateReg != acs_pkg::ACS_IDLE) || fireEvent);
        end
    end

    // analog supply switch, a cycle after the enable; nothing in the
    // analog path draws current while this is low
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            analogPowerOn <= 1'b0;
        end else begin
            analogPowerOn <= cfg.powerEnable;
        end
    end

    // track-and-hold switch, closed only in the sampling phase;
    // opens at once on power loss
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            analogSampling <= 1'b0;
        end else begin
            analogSampling <= cfg.powerEnable && (stateReg == acs_pkg::ACS_SAMPLE);
        end
    end

    // selections forwarded to the analog side; software ordering
    // of channel and source is trusted, not checked here
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            analogCfg <= '0;
        end else begin
            analogCfg <= cfg;
        end
    end

    // request flag: set wins over a clear in the same cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            converterInterruptRequest <= 1'b0;
        end else if (doneEvent) begin
            converterInterruptRequest <= 1'b1;
        end else if (irqFlagClear) begin
            converterInterruptRequest <= 1'b0;
        end
    end
endmodule

// ### verification/acs_props.sv
module acs_props (
    input wire logic mclk,
    input wire logic rst_n,
    input wire acs_pkg::acs_cfg_t cfg,
    input wire logic startBit,
    input wire logic irqFlagClear,
    input wire logic analogPowerOn,
    input wire logic analogSampling,
    input wire logic conversionBusyFlag,
    input wire logic converterInterruptRequest,
    input wire acs_pkg::acs_result_t result
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // power off drops busy and analog power at once
    property p_off; !cfg.powerEnable |=> !conversionBusyFlag && !analogPowerOn; endproperty
    a_off: assert property (p_off) else $error("busy after power off");
    // only a fresh pulse counts, hence the look two back
    property p_go; !$past(startBit, 2) && $fell(startBit) && cfg.powerEnable |=> conversionBusyFlag;
    endproperty
    a_go: assert property (p_go) else $error("start pulse ignored");
    property p_len; $rose(conversionBusyFlag) && cfg.clockSelect == 3'h0
        |-> conversionBusyFlag[*8] ##1 conversionBusyFlag[*8] ##1 !conversionBusyFlag;
    endproperty
    a_len: assert property (p_len) else $error("busy length wrong");
    property p_samp; $fell(analogSampling) && conversionBusyFlag |-> $past(analogSampling, 4);
    endproperty
    a_samp: assert property (p_samp) else $error("sampling too short");
    property p_done; $rose(converterInterruptRequest) |-> $fell(conversionBusyFlag); endproperty
    a_done: assert property (p_done) else $error("request not at completion");
    property p_hold; $changed(result) |-> $fell(conversionBusyFlag); endproperty
    a_hold: assert property (p_hold) else $error("result changed mid-run");
    property p_fmt; $changed(result)
        |-> ($past(cfg.resultFormatSelect) ? result[15:12] : result[3:0]) == 4'h0; endproperty
    a_fmt: assert property (p_fmt) else $error("result layout wrong");
    property p_keep; converterInterruptRequest && !irqFlagClear |=> converterInterruptRequest;
    endproperty
    a_keep: assert property (p_keep) else $error("request lost");
endmodule
bind adc_conversion_sequencer acs_props acs_props_i (.mclk(mclk), .rst_n(rst_n), .cfg(cfg),
    .startBit(startBit), .irqFlagClear(irqFlagClear), .analogPowerOn(analogPowerOn),
    .analogSampling(analogSampling), .conversionBusyFlag(conversionBusyFlag),
    .converterInterruptRequest(converterInterruptRequest), .result(result));

// ### verification/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    acs_pkg::acs_cfg_t cfg = '0;
    logic startBit = 1'b0;
    logic irqFlagClear = 1'b0;
    logic compareHigh = 1'b0;
    logic powerOn, sampling, busy, req;
    acs_pkg::acs_result_t result;
    acs_pkg::acs_cfg_t fwdCfg;
    int nMismatch = 0;
    int nChecks = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h5FF736C2;
    adc_conversion_sequencer adc_conversion_sequencer_i (.mclk(mclk), .rst_n(rst_n), .cfg(cfg),
        .startBit(startBit), .irqFlagClear(irqFlagClear), .compareHigh(compareHigh),
        .analogCfg(fwdCfg), .analogPowerOn(powerOn), .analogSampling(sampling),
        .conversionBusyFlag(busy), .converterInterruptRequest(req), .result(result));
    initial begin
        forever #4 mclk = ~mclk;
    end
    // hang guard, well above twelve slow conversions
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            nMismatch++;
            wrap_up();
        end
    end
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // constant comparator answer gives all-ones or all-zeros code
    function automatic logic [15:0] layout(logic f, logic b);
        return f ? {4'h0, {12{b}}} : {{12{b}}, 4'h0};
    endfunction
    task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
        nChecks++;
        if (s !== e) begin
            nMismatch++;
            $display("wrong value %s exp %h got %h", nm, e, s);
        end
    endtask
    task wrap_up;
        if (nMismatch == 0 && nChecks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one conversion; aborts use slow clocks so power drops mid-run
    task automatic convert(input logic abort);
        int n;
        logic [15:0] old;
        int k;
        logic inner;
        seed = lfsr(seed);
        old = result;
        k = {abort, seed[1:0]};
        inner = seed[8];
        @(posedge mclk);
        cfg.clockSelect <= 3'(k);
        cfg.resultFormatSelect <= seed[2];
        cfg.externalChannelSelect <= inner ? 4'hF : seed[7:4];
        cfg.referenceSelect <= seed[10:9];
        compareHigh <= seed[3];
        startBit <= 1'b1;
        @(posedge mclk);
        cfg.inputSourceSelect <= inner ? 3'h1 : 3'h0;
        startBit <= 1'b0;
        @(posedge mclk);
        for (n = 0; n < 3000; n++) begin
            @(posedge mclk);
            if (abort && n == 6) cfg.powerEnable <= 1'b0;
            #1;
            if (n == 0) chk("sampling", 16'h0001, {15'h0, sampling});
            if (busy !== 1'b1) break;
        end
        if (abort) begin
            chk("abort cycles", 16'h0007, 16'(n));
            chk("abort result", old, result);
            chk("abort request", 16'h0000, {15'h0, req});
            chk("abort power", 16'h0000, {15'h0, powerOn});
            @(posedge mclk);
            cfg.powerEnable <= 1'b1;
        end else begin
            chk("busy len", 16'h0001, 16'(n >= (15 << k) && n < (16 << k)));
            chk("result", layout(seed[2], seed[3]), result);
            chk("request", 16'h0001, {15'h0, req});
            chk("forwarded cfg", {1'b0, cfg}, {1'b0, fwdCfg});
            @(posedge mclk);
            irqFlagClear <= 1'b1;
            @(posedge mclk);
            irqFlagClear <= 1'b0;
            #1;
            chk("cleared", 16'h0000, {15'h0, req});
        end
    endtask
    initial begin
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        cfg.powerEnable <= 1'b1;
        for (int i = 0; i < 12; i++) convert(i % 4 == 3);
        wrap_up();
    end
endmodule
